// *** inc/tsml_pkg.sv ***
// Shared constants and types for the touch scan, mode and LED controller
package tsml_pkg;
  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int PWM_W = 8;
  localparam int TICK_W = 12;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int MS_CYCLES = 1000 * CLK_MHZ;
  localparam int MIN_PERIOD_MS = 15;
  localparam int ACTIVE_PERIOD_MS = 30;
  localparam int DOZE_PERIOD_MS = 195;
  localparam logic [15:0] MS_ONE = 16'h0001;
  // ---------------------------------------------------------------
  // Modes and phases
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TSML_MODE_ACTIVE = 2'b00,
    TSML_MODE_DOZE = 2'b01,
    TSML_MODE_SLEEP = 2'b10
  } tsml_mode_t;
  typedef enum logic [1:0] {
    TSML_PH_SENSE = 2'b00,
    TSML_PH_PROC = 2'b01,
    TSML_PH_TIMER = 2'b10,
    TSML_PH_IDLE = 2'b11
  } tsml_phase_t;
  // Per-pin output function
  localparam logic [1:0] GPIO_LED_AUTO = 2'h0;
  localparam logic [1:0] GPIO_LED_HOST = 2'h1;
  localparam logic [1:0] GPIO_PULSE = 2'h2;
  localparam logic [1:0] GPIO_INPUT = 2'h3;
  // Host mode force: 0 means autonomous
  localparam logic [1:0] FORCE_NONE = 2'h0;
  localparam logic [1:0] FORCE_ACTIVE = 2'h1;
  localparam logic [1:0] FORCE_DOZE = 2'h2;
  localparam logic [1:0] FORCE_SLEEP = 2'h3;
  localparam logic [PWM_W-1:0] PWM_MAX = 8'hff;
  localparam logic [PWM_W-1:0] PWM_ZERO = 8'h00;
endpackage : tsml_pkg

// *** logic/tsml_ctrl.sv ***
// Scan sequencer, operating modes and per-pin LED fading for eight touch inputs
`timescale 1ns/1ns
// Behaviour
// - Scan is sensing, processing, then timer wait
// - Sense enabled inputs zero to seven, skip others
// - Touch status, irq change only in processing; input status also in sleep
// - Late input change reported next processing phase
// - Scan period host set, fifteen ms minimum
// - Reaction time set by scan period
// - Three modes; active default period thirty ms
// - Doze uses longer period, default 195 ms
// - Sleep: no scanning, input sampling continues
// - Active and doze periods programmable separately
// - Inactivity timer to doze, may be disabled
// - Doze touch wakes to active without sequence
// - With sequence option, correct sequence wakes
// - Host forced mode overrides autonomous transitions
// - Default: button n drives LED n, log fade
// - Eight 256-step PWMs, linear or log fade
// - Fade speed, start and end intensity selectable
// - Auto follow: touch starts fade-in itself
// - Host follow: host level high starts fade
// - Pulse mode applies host width without fading
// - Pin may be plain input reported to host
// - New touch or release asserts irq
// - Boot from stored parameters without host
// - Host may overwrite stored parameters afterwards
// - Touch at thresh+hyst, release below thresh-hyst
// - Compensation request accepted only active or doze
module tsml_ctrl import tsml_pkg::*; #(
  parameter int MS_DIV = MS_CYCLES,
  parameter int SEQ_LEN = 2
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Front end measurement handshake
  output logic o_sense_req,
  output logic [2:0] o_sense_sel,
  input wire logic i_sense_done,
  input wire logic [TICK_W-1:0] i_sense_ticks,
  // Configuration (stored parameters, host may override)
  input wire logic i_param_load,
  input wire logic [NUM_CH-1:0] i_sense_en,
  input wire logic [TICK_W-1:0] i_thresh,
  input wire logic [TICK_W-1:0] i_hyst,
  input wire logic [15:0] i_active_period_ms,
  input wire logic [15:0] i_doze_period_ms,
  input wire logic [15:0] i_idle_timeout_scans,
  input wire logic i_seq_en,
  input wire logic [3*SEQ_LEN-1:0] i_seq_keys,
  input wire logic [1:0] i_operating_mode_control,
  input wire logic [2*NUM_CH-1:0] i_gpio_func,
  input wire logic [NUM_CH-1:0] i_fade_log,
  input wire logic [7:0] i_fade_step_div,
  input wire logic [PWM_W-1:0] i_fade_lo,
  input wire logic [PWM_W-1:0] i_fade_hi,
  input wire logic [NUM_CH-1:0] i_host_level,
  input wire logic [NUM_CH*PWM_W-1:0] i_host_pulse_width_mode,
  input wire logic i_comp_req,
  input wire logic i_irq_clear,
  input wire logic [NUM_CH-1:0] i_gpio_pin,
  // Status and pins
  output logic [NUM_CH-1:0] o_touch,
  output logic [NUM_CH-1:0] o_gpi_state,
  output logic [1:0] o_mode,
  output logic o_comp_start,
  output logic o_irq_out_n,
  output logic [NUM_CH-1:0] o_gpio_out,
  output logic [NUM_CH-1:0] o_gpio_oe
);
  if (SEQ_LEN < 1 || SEQ_LEN > 8 || MS_DIV < 2) begin : g_bad_param
    $error("tsml_ctrl: unsupported parameter values");
  end

  // ---------------------------------------------------------------
  // Stored parameter copy: built-in defaults, reloaded on request
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] en_ff;
  logic [15:0] act_ms_ff, doze_ms_ff;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_ff <= {NUM_CH{1'b1}};
      act_ms_ff <= 16'(ACTIVE_PERIOD_MS);
      doze_ms_ff <= 16'(DOZE_PERIOD_MS);
    end else if (i_param_load) begin
      en_ff <= i_sense_en;
      act_ms_ff <= (i_active_period_ms < 16'(MIN_PERIOD_MS)) ?
                   16'(MIN_PERIOD_MS) : i_active_period_ms;
      doze_ms_ff <= (i_doze_period_ms < 16'(MIN_PERIOD_MS)) ?
                    16'(MIN_PERIOD_MS) : i_doze_period_ms;
    end
  end

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] pin_meta_ff, pin_sync_ff;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= i_gpio_pin;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // Scan sequencer
  // ---------------------------------------------------------------
  tsml_phase_t phase_ff;
  tsml_mode_t mode_ff;
  logic [2:0] ch_ff;
  logic [31:0] div_ff;
  logic [15:0] ms_ff;
  logic [NUM_CH-1:0] touch_ff;
  logic [NUM_CH*TICK_W-1:0] ticks_ff;
  logic [15:0] period_ms;
  logic any_en, last_ch, ms_tick;
  assign period_ms = (mode_ff == TSML_MODE_DOZE) ? doze_ms_ff : act_ms_ff;
  assign any_en = |en_ff;
  assign ms_tick = (div_ff == 32'(MS_DIV - 1));
  assign last_ch = (ch_ff == 3'(NUM_CH - 1));

  function automatic logic [2:0] next_en(input logic [NUM_CH-1:0] en, input logic [3:0] from);
    logic [2:0] r;
    logic found;
    r = 3'h0;
    found = 1'b0;
    for (int k = 0; k < NUM_CH; k++) begin
      if (!found && 4'(k) >= from && en[k]) begin
        r = 3'(k);
        found = 1'b1;
      end
    end
    return r;
  endfunction : next_en

  function automatic logic more_en(input logic [NUM_CH-1:0] en, input logic [3:0] from);
    logic r;
    r = 1'b0;
    for (int k = 0; k < NUM_CH; k++) begin
      if (4'(k) >= from && en[k]) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction : more_en

  logic [3:0] after_ch;
  assign after_ch = {1'b0, ch_ff} + 4'h1;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_ff <= TSML_PH_IDLE;
      ch_ff <= 3'h0;
      div_ff <= '0;
      ms_ff <= '0;
      ticks_ff <= '0;
    end else begin
      case (phase_ff)
        TSML_PH_IDLE: begin
          if (mode_ff != TSML_MODE_SLEEP && any_en) begin
            phase_ff <= TSML_PH_SENSE;
            ch_ff <= next_en(en_ff, 4'h0);
          end else if (mode_ff != TSML_MODE_SLEEP) begin
            phase_ff <= TSML_PH_PROC;
          end
          div_ff <= '0;
          ms_ff <= '0;
        end
        TSML_PH_SENSE: begin
          div_ff <= (ms_tick) ? '0 : div_ff + 32'h1;
          if (ms_tick) begin
            ms_ff <= ms_ff + MS_ONE;
          end
          if (mode_ff == TSML_MODE_SLEEP) begin
            phase_ff <= TSML_PH_IDLE;
          end else if (i_sense_done || !en_ff[ch_ff]) begin
            // A channel disabled by a reload mid-scan is skipped, not waited for
            if (i_sense_done) begin
              ticks_ff[ch_ff*TICK_W +: TICK_W] <= i_sense_ticks;
            end
            if (last_ch || !more_en(en_ff, after_ch)) begin
              phase_ff <= TSML_PH_PROC;
            end else begin
              ch_ff <= next_en(en_ff, after_ch);
            end
          end
        end
        TSML_PH_PROC: begin
          div_ff <= (ms_tick) ? '0 : div_ff + 32'h1;
          if (ms_tick) begin
            ms_ff <= ms_ff + MS_ONE;
          end
          phase_ff <= TSML_PH_TIMER;
        end
        TSML_PH_TIMER: begin
          div_ff <= (ms_tick) ? '0 : div_ff + 32'h1;
          if (ms_tick) begin
            ms_ff <= ms_ff + MS_ONE;
          end
          if (mode_ff == TSML_MODE_SLEEP) begin
            phase_ff <= TSML_PH_IDLE;
          end else if (ms_tick && (ms_ff + MS_ONE >= period_ms)) begin
            div_ff <= '0;
            ms_ff <= '0;
            if (any_en) begin
              phase_ff <= TSML_PH_SENSE;
              ch_ff <= next_en(en_ff, 4'h0);
            end else begin
              phase_ff <= TSML_PH_PROC;
            end
          end
        end
        default: phase_ff <= TSML_PH_IDLE;
      endcase
    end
  end
  assign o_sense_req = (phase_ff == TSML_PH_SENSE);
  assign o_sense_sel = ch_ff;

  // ---------------------------------------------------------------
  // Touch decision, status, input report and irq (processing; input report also in sleep)
  // ---------------------------------------------------------------
  logic [NUM_CH-1:0] nxt_touch;
  logic [NUM_CH-1:0] gpi_ff;
  logic irq_ff;
  logic is_proc;
  assign is_proc = (phase_ff == TSML_PH_PROC);
  for (genvar g = 0; g < NUM_CH; g++) begin : g_touch
    logic [TICK_W:0] t, on_lvl, off_lvl;
    assign t = {1'b0, ticks_ff[g*TICK_W +: TICK_W]};
    assign on_lvl = {1'b0, i_thresh} + {1'b0, i_hyst};
    assign off_lvl = {1'b0, i_thresh} - {1'b0, i_hyst};
    assign nxt_touch[g] = !en_ff[g] ? 1'b0 :
                          (t >= on_lvl) ? 1'b1 :
                          // Hysteresis above threshold would wrap: never release
                          (i_hyst <= i_thresh && t < off_lvl) ? 1'b0 : touch_ff[g];
  end
  logic [NUM_CH-1:0] gpi_in;
  for (genvar g = 0; g < NUM_CH; g++) begin : g_gpi
    assign gpi_in[g] = (i_gpio_func[2*g +: 2] == GPIO_INPUT) & pin_sync_ff[g];
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      touch_ff <= '0;
      gpi_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (is_proc) begin
        touch_ff <= nxt_touch;
        gpi_ff <= gpi_in;
      end else if (mode_ff == TSML_MODE_SLEEP) begin
        // No processing runs in sleep, so inputs are reported directly, without irq
        gpi_ff <= gpi_in;
      end
      if (is_proc && (nxt_touch != touch_ff || gpi_in != gpi_ff)) begin
        irq_ff <= 1'b1;
      end else if (i_irq_clear && is_proc) begin
        irq_ff <= 1'b0; // Cleared read-out is also taken at processing time
      end
    end
  end
  assign o_touch = touch_ff;
  assign o_gpi_state = gpi_ff;
  assign o_irq_out_n = ~irq_ff;

  // ---------------------------------------------------------------
  // Operating mode, inactivity counter and wake-up sequence
  // ---------------------------------------------------------------
  logic [15:0] idle_ff;
  logic [3:0] seq_ff;
  logic [NUM_CH-1:0] rel;
  logic [2:0] rel_key;
  logic rel_any;
  assign rel = touch_ff & ~nxt_touch;
  assign rel_any = |rel;
  always_comb begin
    rel_key = 3'h0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (rel[k]) begin
        rel_key = 3'(k);
      end
    end
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_ff <= TSML_MODE_ACTIVE;
      idle_ff <= '0;
      seq_ff <= '0;
    end else if (i_operating_mode_control != FORCE_NONE) begin
      mode_ff <= (i_operating_mode_control == FORCE_ACTIVE) ? TSML_MODE_ACTIVE :
                 (i_operating_mode_control == FORCE_DOZE) ? TSML_MODE_DOZE :
                 TSML_MODE_SLEEP;
      idle_ff <= '0;
      seq_ff <= '0;
    end else if (mode_ff == TSML_MODE_SLEEP) begin
      mode_ff <= TSML_MODE_ACTIVE; // Release of a forced sleep resumes scanning
    end else if (is_proc) begin
      if (mode_ff == TSML_MODE_ACTIVE) begin
        seq_ff <= '0;
        if (|nxt_touch) begin
          idle_ff <= '0;
        end else if (i_idle_timeout_scans != 16'h0000) begin
          if (idle_ff + 16'h1 >= i_idle_timeout_scans) begin
            mode_ff <= TSML_MODE_DOZE;
            idle_ff <= '0;
          end else begin
            idle_ff <= idle_ff + 16'h1;
          end
        end
      end else if (!i_seq_en) begin
        if (|(nxt_touch & ~touch_ff)) begin
          mode_ff <= TSML_MODE_ACTIVE;
        end
      end else if (rel_any) begin
        if (rel_key == i_seq_keys[3*seq_ff[2:0] +: 3]) begin
          if (seq_ff + 4'h1 >= 4'(SEQ_LEN)) begin
            mode_ff <= TSML_MODE_ACTIVE;
            seq_ff <= '0;
          end else begin
            seq_ff <= seq_ff + 4'h1;
          end
        end else begin
          seq_ff <= '0;
        end
      end
    end
  end
  assign o_mode = mode_ff;
  assign o_comp_start = i_comp_req && (mode_ff != TSML_MODE_SLEEP);

  // ---------------------------------------------------------------
  // Per-pin fading PWM
  // ---------------------------------------------------------------
  logic [PWM_W-1:0] pwm_cnt_ff;
  logic [7:0] step_ff;
  logic step_tick;
  assign step_tick = (step_ff == i_fade_step_div);
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwm_cnt_ff <= PWM_ZERO;
      step_ff <= '0;
    end else begin
      pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
      if (pwm_cnt_ff == PWM_MAX) begin
        step_ff <= step_tick ? 8'h00 : step_ff + 8'h01;
      end
    end
  end
  for (genvar g = 0; g < NUM_CH; g++) begin : g_led
    logic [PWM_W-1:0] lvl_ff, tgt, nxt_lvl, inc;
    logic [1:0] fn;
    logic on_req_ff;
    assign fn = i_gpio_func[2*g +: 2];
    // Log fade scales the step with the level, so low levels move slowly
    assign inc = i_fade_log[g] ? ((lvl_ff >> 3) | 8'h01) : 8'h01;
    assign tgt = on_req_ff ? i_fade_hi : i_fade_lo;
    always_comb begin
      nxt_lvl = lvl_ff;
      if (lvl_ff < tgt) begin
        nxt_lvl = (tgt - lvl_ff < inc) ? tgt : lvl_ff + inc;
      end else if (lvl_ff > tgt) begin
        nxt_lvl = (lvl_ff - tgt < inc) ? tgt : lvl_ff - inc;
      end
    end
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        on_req_ff <= 1'b0;
        lvl_ff <= PWM_ZERO;
      end else begin
        if (is_proc) begin
          on_req_ff <= (fn == GPIO_LED_AUTO) ? nxt_touch[g] : i_host_level[g];
        end
        if (fn == GPIO_PULSE) begin
          lvl_ff <= i_host_pulse_width_mode[g*PWM_W +: PWM_W];
        end else if (pwm_cnt_ff == PWM_MAX && step_tick) begin
          lvl_ff <= nxt_lvl;
        end
      end
    end
    logic out_ff;
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        out_ff <= 1'b0;
      end else begin
        out_ff <= (lvl_ff == PWM_MAX) || (pwm_cnt_ff < lvl_ff);
      end
    end
    assign o_gpio_out[g] = out_ff;
    assign o_gpio_oe[g] = (fn != GPIO_INPUT);
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  irq_in_proc_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $fell(o_irq_out_n) |-> $past(phase_ff) == TSML_PH_PROC)
    else $error("irq asserted outside processing");
  touch_in_proc_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !$stable(touch_ff) |-> $past(is_proc))
    else $error("touch status changed outside processing");
  no_scan_sleep_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    mode_ff == TSML_MODE_SLEEP |=> !o_sense_req)
    else $error("scan started in sleep");
  proc_then_timer_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    is_proc |=> phase_ff == TSML_PH_TIMER)
    else $error("processing not followed by timer");
  sel_enabled_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_sense_req |-> en_ff[o_sense_sel] || $changed(en_ff) || $past(i_param_load))
    else $error("disabled input measured");
  force_mode_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_operating_mode_control == FORCE_DOZE |=> mode_ff == TSML_MODE_DOZE)
    else $error("forced mode not applied");
  comp_gate_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_comp_start |-> mode_ff != TSML_MODE_SLEEP)
    else $error("compensation started in sleep");
  period_min_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    act_ms_ff >= 16'(MIN_PERIOD_MS) && doze_ms_ff >= 16'(MIN_PERIOD_MS))
    else $error("scan period below minimum");
  scan_cov_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    phase_ff == TSML_PH_TIMER ##1 phase_ff == TSML_PH_SENSE);
  doze_cov_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    $changed(mode_ff) && mode_ff == TSML_MODE_DOZE);
  wake_cov_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    $past(mode_ff) == TSML_MODE_DOZE && mode_ff == TSML_MODE_ACTIVE);
endmodule : tsml_ctrl

// *** test/tsml_front_model.sv ***
// Behavioural sensing front end that answers channel measurement requests
`timescale 1ns/1ns
module tsml_front_model import tsml_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_sense_req,
  input wire logic [2:0] i_sense_sel,
  input wire logic [2:0] i_delay,
  input wire logic [NUM_CH-1:0] i_press,
  input wire logic [TICK_W-1:0] i_hi,
  input wire logic [TICK_W-1:0] i_lo,
  output logic o_done,
  output logic [TICK_W-1:0] o_ticks
);
  logic [2:0] wait_ff;
  logic [TICK_W-1:0] junk_ff;
  // Outside done the tick bus churns, so nothing may lean on a stale count
  assign o_ticks = o_done ? (i_press[i_sense_sel] ? i_hi : i_lo) : junk_ff;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
      wait_ff <= 3'h0;
      junk_ff <= 12'h5a5;
    end else begin
      junk_ff <= ~junk_ff + 12'h001;
      if (!i_sense_req || o_done) begin
        o_done <= 1'b0;
        wait_ff <= 3'h0;
      end else if (wait_ff == i_delay) begin
        o_done <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 3'h1;
      end
    end
  end
endmodule : tsml_front_model

// *** test/test_touch_scan_mode_led_control.sv ***
// Self-checking bench for scan order, periods, touch status, modes and pins
`timescale 1ns/1ns
module test_touch_scan_mode_led_control;
  import tsml_pkg::*;
  localparam int DIV = 10;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_param_load = 1'b0, i_seq_en = 1'b0, i_comp_req = 1'b0, i_irq_clear = 1'b0;
  logic [NUM_CH-1:0] i_sense_en = 8'hff, i_host_level = 8'h00, i_gpio_pin = 8'h00;
  logic [NUM_CH-1:0] i_fade_log = 8'hff, press = 8'h00;
  logic [TICK_W-1:0] i_thresh = 12'h100, i_hyst = 12'h010, t_hi = 12'h000, t_lo = 12'h000;
  logic [15:0] i_active_period_ms = 16'h000f, i_doze_period_ms = 16'h0014;
  logic [15:0] i_idle_timeout_scans = 16'h0000;
  logic [5:0] i_seq_keys = 6'h00;
  logic [1:0] i_operating_mode_control = 2'h0;
  logic [2*NUM_CH-1:0] i_gpio_func = 16'h0000;
  logic [7:0] i_fade_step_div = 8'h00, i_fade_lo = 8'h00, i_fade_hi = 8'hff;
  logic [NUM_CH*PWM_W-1:0] i_host_pulse_width_mode = 64'h0;
  logic [2:0] dly = 3'h0;
  logic o_sense_req, i_sense_done, o_comp_start, o_irq_out_n;
  logic [2:0] o_sense_sel;
  logic [TICK_W-1:0] i_sense_ticks;
  logic [NUM_CH-1:0] o_touch, o_gpi_state, o_gpio_out, o_gpio_oe;
  logic [1:0] o_mode;
  logic [31:0] lfsr = 32'h22d5;
  int fails = 0, checks = 0, n, k;
  logic [2:0] seen_q[$];

  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (o_sense_req && i_sense_done) seen_q.push_back(o_sense_sel);

  tsml_ctrl #(.MS_DIV(DIV), .SEQ_LEN(2)) i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .o_sense_req(o_sense_req), .o_sense_sel(o_sense_sel), .i_sense_done(i_sense_done),
    .i_sense_ticks(i_sense_ticks), .i_param_load(i_param_load), .i_sense_en(i_sense_en),
    .i_thresh(i_thresh), .i_hyst(i_hyst), .i_active_period_ms(i_active_period_ms),
    .i_doze_period_ms(i_doze_period_ms), .i_idle_timeout_scans(i_idle_timeout_scans),
    .i_seq_en(i_seq_en), .i_seq_keys(i_seq_keys),
    .i_operating_mode_control(i_operating_mode_control), .i_gpio_func(i_gpio_func),
    .i_fade_log(i_fade_log), .i_fade_step_div(i_fade_step_div), .i_fade_lo(i_fade_lo),
    .i_fade_hi(i_fade_hi), .i_host_level(i_host_level),
    .i_host_pulse_width_mode(i_host_pulse_width_mode), .i_comp_req(i_comp_req),
    .i_irq_clear(i_irq_clear), .i_gpio_pin(i_gpio_pin), .o_touch(o_touch),
    .o_gpi_state(o_gpi_state), .o_mode(o_mode), .o_comp_start(o_comp_start),
    .o_irq_out_n(o_irq_out_n), .o_gpio_out(o_gpio_out), .o_gpio_oe(o_gpio_oe));

  tsml_front_model i_front (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sense_req(o_sense_req),
    .i_sense_sel(o_sense_sel), .i_delay(dly), .i_press(press), .i_hi(t_hi), .i_lo(t_lo),
    .o_done(i_sense_done), .o_ticks(i_sense_ticks));

  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd

  function automatic logic [2:0] nth_set(input logic [7:0] m, input int i);
    int c = 0;
    for (int b = 0; b < 8; b++) if (m[b]) begin
      if (c == i) return 3'(b);
      c++;
    end
    return 3'h0;
  endfunction : nth_set

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  // Inputs move 1 ns after the edge, clear of the sampling instant
  task automatic step(input int c);
    repeat (c) @(posedge i_mclk);
    #1;
  endtask : step

  // Wait for o_sense_req to change to v, returning the cycles spent
  task automatic wait_req(input logic v, output int c);
    logic p;
    p = o_sense_req;
    c = 0;
    while (!(o_sense_req === v && p !== v) && c < 4000) begin
      p = o_sense_req;
      step(1);
      c++;
    end
    if (c >= 4000) begin
      fails++;
      end_of_test();
    end
  endtask : wait_req

  task automatic scans(input int c);
    repeat (c) wait_req(1'b1, n);
  endtask : scans

  task automatic seen_high(input int pin, output logic hi);
    hi = 1'b0;
    repeat (1200) begin
      step(1);
      hi = hi | o_gpio_out[pin];
    end
  endtask : seen_high

  task automatic load();
    i_param_load = 1'b1;
    step(1);
    i_param_load = 1'b0;
  endtask : load

  initial begin
    logic hi;
    logic [7:0] m;
    int ms;
    step(10);
    check(16'({o_touch, o_gpio_oe}), 16'h00ff);
    check(16'({o_irq_out_n, o_mode}), 16'h0004);
    i_rst_n = 1'b1;
    load();
    // ---------------------------------------------
    // Sensing order and scan period
    // ---------------------------------------------
    for (int r = 0; r < 4; r++) begin
      lfsr = rnd(lfsr);
      m = (r == 0) ? 8'h80 : (r == 3) ? 8'hff : (lfsr[7:0] | 8'h01);
      dly = lfsr[10:8];
      ms = (r == 3) ? 10 : 15 + r;
      i_sense_en = m;
      i_active_period_ms = 16'(ms);
      load();
      scans(2);
      seen_q.delete();
      wait_req(1'b1, n);
      check(16'(n), 16'((ms < MIN_PERIOD_MS ? MIN_PERIOD_MS : ms) * DIV));
      check(16'(seen_q.size()), 16'($countones(m)));
      foreach (seen_q[i]) check(16'(seen_q[i]), 16'(nth_set(m, i)));
    end
    $display("test scan order and period finished");
    // ---------------------------------------------
    // Touch thresholds, interrupt and pin functions
    // ---------------------------------------------
    i_gpio_func = 16'h006c;
    i_fade_log = lfsr[15:8];
    step(1);
    check(16'(o_gpio_oe[3:0]), 16'hd);
    for (int r = 0; r < 4; r++) begin
      i_irq_clear = 1'b1;
      scans(2);
      i_irq_clear = 1'b0;
      press = (r < 2) ? 8'h01 : 8'h00;
      t_hi = (r == 0) ? 12'h10f : 12'h110;
      t_lo = (r == 2) ? 12'h0f0 : 12'h0ef;
      scans(2);
      check(16'(o_touch), (r == 1 || r == 2) ? 16'h1 : 16'h0);
      check(16'(o_irq_out_n), (r == 1 || r == 3) ? 16'h0 : 16'h1);
      if (r == 1) begin
        seen_high(0, hi);
        check(16'(hi), 16'h1);
      end
    end
    seen_high(3, hi);
    check(16'(hi), 16'h0);
    i_host_level = 8'h08;
    seen_high(3, hi);
    check(16'(hi), 16'h1);
    seen_high(2, hi);
    check(16'(hi), 16'h0);
    i_host_pulse_width_mode = 64'h0000_0000_00ff_0000;
    seen_high(2, hi);
    check(16'(hi), 16'h1);
    wait_req(1'b0, n);
    step(3);
    lfsr = rnd(lfsr);
    i_gpio_pin = lfsr[7:0] | 8'h02;
    wait_req(1'b1, n);
    check(16'(o_gpi_state[1]), 16'h0);
    wait_req(1'b0, n);
    step(3);
    check(16'(o_gpi_state[1]), 16'h1);
    $display("test touch and pins finished");
    // ---------------------------------------------
    // Operating modes
    // ---------------------------------------------
    i_idle_timeout_scans = 16'h0002;
    k = 0;
    while (o_mode !== TSML_MODE_DOZE && k < 8) begin
      wait_req(1'b1, n);
      k++;
    end
    check(16'(o_mode), 16'(TSML_MODE_DOZE));
    scans(1);
    wait_req(1'b1, n);
    check(16'(n), 16'(20 * DIV));
    press = 8'h01;
    t_hi = 12'h110;
    scans(3);
    check(16'(o_mode), 16'(TSML_MODE_ACTIVE));
    press = 8'h00;
    i_idle_timeout_scans = 16'h0000;
    scans(5);
    check(16'(o_mode), 16'(TSML_MODE_ACTIVE));
    for (int f = 1; f < 4; f++) begin
      i_operating_mode_control = 2'(f);
      k = 0;
      while (o_mode !== 2'(f - 1) && k < 3000) begin
        step(1);
        k++;
      end
      check(16'(o_mode), 16'(f - 1));
    end
    i_comp_req = 1'b1;
    i_gpio_pin = 8'h00;
    hi = 1'b0;
    repeat (500) begin
      step(1);
      hi = hi | o_sense_req | o_comp_start;
    end
    check(16'(hi), 16'h0);
    check(16'(o_gpi_state[1]), 16'h0);
    i_operating_mode_control = FORCE_DOZE;
    k = 0;
    while (o_mode !== TSML_MODE_DOZE && k < 3000) begin
      step(1);
      k++;
    end
    check(16'(o_comp_start), 16'h1);
    // Wake sequence: key 2 then key 1, touched and released, from doze
    i_operating_mode_control = FORCE_NONE;
    i_seq_en = 1'b1;
    i_seq_keys = 6'h0a;
    for (int s = 0; s < 4; s++) begin
      press = (s == 0) ? 8'h04 : (s == 2) ? 8'h02 : 8'h00;
      scans(2);
      check(16'(o_mode), (s == 3) ? 16'(TSML_MODE_ACTIVE) : 16'(TSML_MODE_DOZE));
    end
    $display("test modes finished");
    end_of_test();
  end
endmodule : test_touch_scan_mode_led_control
